// ===== design/switch_power_mode_consts.svh
// constants for the switch power mode controller
`ifndef SWITCH_POWER_MODE_CONSTS_SVH
`define SWITCH_POWER_MODE_CONSTS_SVH
// ****************************************
// register offsets
// ****************************************
`define ADDR_PORT1_PHY_CONTROL 8'h1D
`define ADDR_PORT2_PHY_CONTROL 8'h2D
`define ADDR_POWER_MODE_CONTROL 8'hC3
`define ADDR_SLEEP_IDLE_TIMEOUT 8'hC4
// ****************************************
// fields and reset values
// ****************************************
`define PORT_POWER_DOWN_BIT 3
`define PLL_OFF_BIT 2
`define MODE_LSB 0
`define MODE_MSB 1
`define MODE_NORMAL 2'h0
`define MODE_ENERGY 2'h1
`define MODE_SOFT_DOWN 2'h2
`define MODE_SAVING 2'h3
`define RESET_BYTE 8'h00
`define RESET_TIMEOUT 8'hFF
`define ENABLE_ON 1'b1
`define PORTS_ON 2'h3
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 4
`define PULSE_WIDTH_NS 120
`define PULSE_CYCLES (`PULSE_WIDTH_NS / `CLK_PERIOD_NS)
`define PULSE_PERIOD_NS 1000000000
`define PULSE_PERIOD_CYCLES (`PULSE_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_NS 1000000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`endif

// ===== design/switch_power_mode_pkg.sv
// types for the switch power mode controller
package switch_power_mode_pkg;
  typedef enum logic [2:0]
  {
    st_normal = 3'h0,
    st_energy_awake = 3'h1,
    st_energy_sleep = 3'h2,
    st_soft_down = 3'h3,
    st_saving_wait = 3'h4,
    st_saving_idle = 3'h5,
    st_hard_down = 3'h6
  } power_state_type;
endpackage : switch_power_mode_pkg

// ===== design/switch_power_mode_control.sv
// power mode controller for a three-port switch with two phys
`include "switch_power_mode_consts.svh"
module switch_power_mode_control #(
  parameter int unsigned PULSE_PERIOD = `PULSE_PERIOD_CYCLES,
  parameter int unsigned TICK_PERIOD = `TICK_CYCLES
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic chip_shutdown_n,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [1:0] miim_port_power_down,
  input wire logic autoneg_enable,
  input wire logic [1:0] cable_connected,
  input wire logic [1:0] cable_energy,
  output logic pll_clock_enable,
  output logic mac_enable,
  output logic host_if_enable,
  output logic [1:0] phy_tx_enable,
  output logic [1:0] phy_rx_enable,
  output logic [1:0] energy_detect_enable,
  output logic [1:0] link_pulse,
  output logic [2:0] power_state
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    // host registers
    logic [7:0] port1_phy_control;
    logic [7:0] port2_phy_control;
    logic [7:0] power_mode_control;
    logic [7:0] sleep_idle_timeout;
    // sequencing
    switch_power_mode_pkg::power_state_type state;
    logic [31:0] tick_count;
    logic [7:0] idle_ticks;
    logic [31:0] pulse_count;
    // read port
    logic [7:0] rdata;
    logic rvalid;
    // registered block enables and link pulses
    logic pll_en;
    logic mac_en;
    logic host_en;
    logic [1:0] tx_en;
    logic [1:0] rx_en;
    logic [1:0] ed_en;
    logic [1:0] pulse;
  } ctrl_type;

  ctrl_type r;
  ctrl_type next_r;

  // ****************************************
  // constants
  // ****************************************
  localparam logic [31:0] TICK_LAST = 32'(TICK_PERIOD - 1);
  localparam logic [31:0] PULSE_LAST = 32'(PULSE_PERIOD - 1);
  localparam logic [31:0] PULSE_HIGH = 32'(`PULSE_CYCLES);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [1:0] mode_of(input logic [7:0] value);
    mode_of = value[`MODE_MSB:`MODE_LSB];
  endfunction : mode_of

  // a port is off by its own control bit or by the management path
  function automatic logic port_off(input logic [7:0] control, input logic miim_down);
    port_off = control[`PORT_POWER_DOWN_BIT] | miim_down;
  endfunction : port_off

  // free-running counter that wraps after its last value
  function automatic logic [31:0] count_step(input logic [31:0] value, input logic [31:0] last);
    if (value >= last)
    begin
      count_step = '0;
    end
    else
    begin
      count_step = value + 32'h1;
    end
  endfunction : count_step

  function automatic logic in_energy_mode(input switch_power_mode_pkg::power_state_type state);
    in_energy_mode = (state == switch_power_mode_pkg::st_energy_awake) ||
                     (state == switch_power_mode_pkg::st_energy_sleep);
  endfunction : in_energy_mode

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [1:0] mode;
    logic [1:0] port_down;
    logic any_energy;
    logic all_unplugged;
    logic tick;
    mode = mode_of(r.power_mode_control);
    port_down = '0;
    any_energy = |cable_energy;
    all_unplugged = ~|cable_connected;
    tick = 1'b0;
    next_r = r;
    next_r.rvalid = 1'b0;

    // ****************************************
    // register access
    // ****************************************
    // register writes are taken in every state while chip_shutdown_n is high and refused while it is low
    if (reg_write && chip_shutdown_n)
    begin
      case (reg_addr)
        `ADDR_PORT1_PHY_CONTROL: next_r.port1_phy_control = reg_wdata;
        `ADDR_PORT2_PHY_CONTROL: next_r.port2_phy_control = reg_wdata;
        `ADDR_POWER_MODE_CONTROL: next_r.power_mode_control = reg_wdata;
        `ADDR_SLEEP_IDLE_TIMEOUT: next_r.sleep_idle_timeout = reg_wdata;
        default: next_r.rdata = r.rdata;
      endcase
    end
    // a refused read gives no valid strobe and leaves the data as it was
    if (reg_read && r.host_en)
    begin
      next_r.rvalid = 1'b1;
      case (reg_addr)
        `ADDR_PORT1_PHY_CONTROL: next_r.rdata = r.port1_phy_control;
        `ADDR_PORT2_PHY_CONTROL: next_r.rdata = r.port2_phy_control;
        `ADDR_POWER_MODE_CONTROL: next_r.rdata = r.power_mode_control;
        `ADDR_SLEEP_IDLE_TIMEOUT: next_r.rdata = r.sleep_idle_timeout;
        default: next_r.rdata = `RESET_BYTE;
      endcase
    end
    port_down[0] = port_off(r.port1_phy_control, miim_port_power_down[0]);
    port_down[1] = port_off(r.port2_phy_control, miim_port_power_down[1]);

    // ****************************************
    // idle timer tick
    // ****************************************
    // one idle unit of the sleep timeout per tick
    tick = (r.tick_count >= TICK_LAST);
    next_r.tick_count = count_step(r.tick_count, TICK_LAST);

    // ****************************************
    // state selection
    // ****************************************
    case (r.state)
      switch_power_mode_pkg::st_normal:
      begin
        case (mode)
          `MODE_ENERGY: next_r.state = switch_power_mode_pkg::st_energy_awake;
          `MODE_SOFT_DOWN: next_r.state = switch_power_mode_pkg::st_soft_down;
          `MODE_SAVING: next_r.state = switch_power_mode_pkg::st_saving_wait;
          default: next_r.state = switch_power_mode_pkg::st_normal;
        endcase
        next_r.idle_ticks = '0;
      end
      switch_power_mode_pkg::st_energy_awake:
      begin
        if (mode != `MODE_ENERGY)
          next_r.state = switch_power_mode_pkg::st_normal;
        else if (any_energy)
          next_r.idle_ticks = '0;
        else if (tick)
        begin
          if (r.idle_ticks >= r.sleep_idle_timeout)
            next_r.state = switch_power_mode_pkg::st_energy_sleep;
          else
            next_r.idle_ticks = r.idle_ticks + 8'h1;
        end
      end
      switch_power_mode_pkg::st_energy_sleep:
      begin
        next_r.idle_ticks = '0;
        if (mode != `MODE_ENERGY || any_energy)
          next_r.state = (mode == `MODE_ENERGY) ? switch_power_mode_pkg::st_energy_awake
                                                : switch_power_mode_pkg::st_normal;
      end
      switch_power_mode_pkg::st_soft_down:
      begin
        if (mode == `MODE_NORMAL)
          next_r.state = switch_power_mode_pkg::st_normal;
        else if (mode != `MODE_SOFT_DOWN)
          next_r.state = switch_power_mode_pkg::st_normal;
      end
      switch_power_mode_pkg::st_saving_wait:
      begin
        if (mode != `MODE_SAVING)
          next_r.state = switch_power_mode_pkg::st_normal;
        else if (autoneg_enable && all_unplugged && !any_energy)
          next_r.state = switch_power_mode_pkg::st_saving_idle;
      end
      switch_power_mode_pkg::st_saving_idle:
      begin
        if (mode != `MODE_SAVING)
          next_r.state = switch_power_mode_pkg::st_normal;
        else if (any_energy || !all_unplugged || !autoneg_enable)
          next_r.state = switch_power_mode_pkg::st_saving_wait;
      end
      switch_power_mode_pkg::st_hard_down:
      begin
        // registers keep their contents across a hard power down
        next_r.state = switch_power_mode_pkg::st_normal;
      end
      default: next_r.state = switch_power_mode_pkg::st_normal;
    endcase
    if (!chip_shutdown_n)
    begin
      next_r.state = switch_power_mode_pkg::st_hard_down;
    end

    // ****************************************
    // link pulses while unplugged in energy mode
    // ****************************************
    next_r.pulse = '0;
    if (in_energy_mode(next_r.state))
    begin
      next_r.pulse_count = count_step(r.pulse_count, PULSE_LAST);
      // the count of this cycle decides, so the first pulse is full width
      if (r.pulse_count < PULSE_HIGH)
      begin
        next_r.pulse = ~cable_connected & ~port_down;
      end
    end
    else
    begin
      next_r.pulse_count = '0;
    end

    // ****************************************
    // block enables
    // ****************************************
    // taken from the next state so enables change with the state itself
    case (next_r.state)
      switch_power_mode_pkg::st_normal:
      begin
        next_r.pll_en = 1'b1;
        next_r.mac_en = 1'b1;
        next_r.host_en = 1'b1;
        next_r.tx_en = ~port_down;
        next_r.rx_en = ~port_down;
        next_r.ed_en = ~port_down;
      end
      switch_power_mode_pkg::st_energy_awake:
      begin
        next_r.pll_en = ~r.power_mode_control[`PLL_OFF_BIT];
        next_r.mac_en = 1'b1;
        next_r.host_en = 1'b1;
        next_r.tx_en = ~port_down;
        next_r.rx_en = ~port_down;
        next_r.ed_en = ~port_down;
      end
      switch_power_mode_pkg::st_energy_sleep:
      begin
        next_r.pll_en = 1'b0;
        next_r.mac_en = 1'b0;
        next_r.host_en = 1'b0;
        next_r.tx_en = '0;
        next_r.rx_en = '0;
        next_r.ed_en = ~port_down;
      end
      switch_power_mode_pkg::st_saving_wait:
      begin
        next_r.pll_en = 1'b1;
        next_r.mac_en = 1'b1;
        next_r.host_en = 1'b1;
        next_r.tx_en = ~port_down;
        next_r.rx_en = ~port_down;
        next_r.ed_en = ~port_down;
      end
      switch_power_mode_pkg::st_saving_idle:
      begin
        next_r.pll_en = 1'b1;
        next_r.mac_en = 1'b1;
        next_r.host_en = 1'b1;
        next_r.tx_en = ~port_down;
        next_r.rx_en = '0;
        next_r.ed_en = ~port_down;
      end
      default:
      begin
        next_r.pll_en = 1'b0;
        next_r.mac_en = 1'b0;
        next_r.host_en = 1'b0;
        next_r.tx_en = '0;
        next_r.rx_en = '0;
        next_r.ed_en = '0;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      r.port1_phy_control <= `RESET_BYTE;
      r.port2_phy_control <= `RESET_BYTE;
      r.power_mode_control <= `RESET_BYTE;
      r.sleep_idle_timeout <= `RESET_TIMEOUT;
      r.state <= switch_power_mode_pkg::st_normal;
      r.tick_count <= '0;
      r.idle_ticks <= '0;
      r.pulse_count <= '0;
      r.rdata <= `RESET_BYTE;
      r.rvalid <= 1'b0;
      r.pll_en <= `ENABLE_ON;
      r.mac_en <= `ENABLE_ON;
      r.host_en <= `ENABLE_ON;
      r.tx_en <= `PORTS_ON;
      r.rx_en <= `PORTS_ON;
      r.ed_en <= `PORTS_ON;
      r.pulse <= '0;
    end
    else if (clk_en)
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = r.rdata;
  assign reg_rvalid = r.rvalid;
  assign pll_clock_enable = r.pll_en;
  assign mac_enable = r.mac_en;
  assign host_if_enable = r.host_en;
  assign phy_tx_enable = r.tx_en;
  assign phy_rx_enable = r.rx_en;
  assign energy_detect_enable = r.ed_en;
  assign link_pulse = r.pulse;
  assign power_state = r.state;

endmodule : switch_power_mode_control

// ===== testbench/switch_power_mode_sva.sv
// port assertions for the power mode controller
module switch_power_mode_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_shutdown_n,
  input wire logic autoneg_enable,
  input wire logic [1:0] cable_connected,
  input wire logic [1:0] cable_energy,
  input wire logic pll_clock_enable,
  input wire logic mac_enable,
  input wire logic host_if_enable,
  input wire logic [1:0] phy_tx_enable,
  input wire logic [1:0] energy_detect_enable,
  input wire logic [1:0] link_pulse,
  input wire logic [2:0] power_state
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] high_count;
  // high cycles of the port 1 pulse so far
  always_ff @(posedge clk)
  begin
    if (!reset_n || !link_pulse[0])
      high_count <= 8'h00;
    else
      high_count <= high_count + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_reset_normal;
    $rose(reset_n) |-> power_state == 3'h0;
  endproperty
  a_reset_normal: assert property (p_reset_normal) else $error("reset state");
  property p_normal_on;
    power_state == 3'h0 |-> pll_clock_enable && mac_enable && host_if_enable;
  endproperty
  a_normal_on: assert property (p_normal_on) else $error("normal enables");
  property p_soft_off;
    power_state == 3'h3 |-> !pll_clock_enable && !mac_enable && phy_tx_enable == 2'h0;
  endproperty
  a_soft_off: assert property (p_soft_off) else $error("soft down enables");
  property p_saving_idle;
    power_state == 3'h5 |-> $past(autoneg_enable) && $past(cable_connected) == 2'h0
      && pll_clock_enable && mac_enable;
  endproperty
  a_saving_idle: assert property (p_saving_idle) else $error("saving idle");
  property p_sleep;
    power_state == 3'h2 |-> energy_detect_enable != 2'h0 && !pll_clock_enable && !mac_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep enables");
  property p_wake;
    power_state == 3'h2 && cable_energy != 2'h0 |=> power_state == 3'h1;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_pulse;
    $fell(link_pulse[0]) && power_state inside {3'h1, 3'h2} && cable_connected == 2'h0
      && $past(cable_connected) == 2'h0 |-> high_count == 8'h1E;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width");
  property p_shutdown;
    !chip_shutdown_n [*3] |-> power_state == 3'h6 && !pll_clock_enable && !host_if_enable;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("hard down");
endmodule : switch_power_mode_sva
bind switch_power_mode_control switch_power_mode_sva switch_power_mode_sva_inst (
  .clk(clk), .reset_n(reset_n), .chip_shutdown_n(chip_shutdown_n),
  .autoneg_enable(autoneg_enable), .cable_connected(cable_connected),
  .cable_energy(cable_energy), .pll_clock_enable(pll_clock_enable), .mac_enable(mac_enable),
  .host_if_enable(host_if_enable), .phy_tx_enable(phy_tx_enable),
  .energy_detect_enable(energy_detect_enable), .link_pulse(link_pulse),
  .power_state(power_state));

// ===== testbench/switch_cable_partner.sv
// cable and far end model for both ports
module switch_cable_partner (
  input wire logic clk,
  input wire logic [1:0] plugged,
  input wire logic [1:0] far_active,
  output logic [1:0] cable_connected,
  output logic [1:0] cable_energy
);
  timeunit 1ns;
  timeprecision 1ps;
  // changes just after the sampling edge, never racing the bench
  always @(posedge clk)
  begin
    cable_connected <= plugged;
    cable_energy <= plugged & far_active;
  end
endmodule : switch_cable_partner

// ===== testbench/switch_power_mode_control_tb_top.sv
// self-checking bench for the power mode controller
module switch_power_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {
    logic [7:0] wval;
    logic [2:0] state;
    logic [2:0] en;
  } row_type;
  row_type rows [8] = '{'{8'h01, 3'h1, 3'h7}, '{8'h00, 3'h0, 3'h7}, '{8'h05, 3'h1, 3'h3},
    '{8'h00, 3'h0, 3'h7}, '{8'h03, 3'h4, 3'h7}, '{8'h00, 3'h0, 3'h7}, '{8'h02, 3'h3, 3'h0},
    '{8'h00, 3'h0, 3'h7}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic chip_shutdown_n = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] miim_port_power_down = 2'h0;
  logic autoneg_enable = 1'b0;
  logic [1:0] plugged = 2'h3;
  logic [1:0] far_active = 2'h0;
  logic [7:0] reg_rdata;
  logic [2:0] power_state;
  logic [1:0] cable_connected, cable_energy, phy_tx_enable, phy_rx_enable;
  logic [1:0] energy_detect_enable, link_pulse;
  logic reg_rvalid, pll_clock_enable, mac_enable, host_if_enable;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int n = 0;
  always #2 clk = ~clk;
  switch_power_mode_control #(.PULSE_PERIOD(100), .TICK_PERIOD(4))
    switch_power_mode_control_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .chip_shutdown_n(chip_shutdown_n), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .miim_port_power_down(miim_port_power_down),
    .autoneg_enable(autoneg_enable), .cable_connected(cable_connected),
    .cable_energy(cable_energy), .pll_clock_enable(pll_clock_enable), .mac_enable(mac_enable),
    .host_if_enable(host_if_enable), .phy_tx_enable(phy_tx_enable),
    .phy_rx_enable(phy_rx_enable), .energy_detect_enable(energy_detect_enable),
    .link_pulse(link_pulse), .power_state(power_state));
  switch_cable_partner switch_cable_partner_inst (.clk(clk), .plugged(plugged),
    .far_active(far_active), .cable_connected(cable_connected), .cable_energy(cable_energy));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    if (reg_rvalid !== 1'b1)
      @(negedge clk);
    check("rvalid", 8'h01, 8'(reg_rvalid));
    check("rdata", d, reg_rdata);
  endtask : rd
  task automatic st(input logic [2:0] s, input logic [2:0] e);
    check("state", 8'(s), 8'(power_state));
    check("enables", 8'(e), 8'({pll_clock_enable, mac_enable, host_if_enable}));
  endtask : st
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      test_done();
    end
  end
  initial
  begin
    idle(16);
    reset_n = 1'b1;
    st(3'h0, 3'h7);
    rd(8'hC3, 8'h00);
    rd(8'hC4, 8'hFF);
    rd(8'h55, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'hC3, rows[i].wval);
      idle(4);
      st(rows[i].state, rows[i].en);
    end
    wr(8'h1D, 8'h08);
    miim_port_power_down = 2'h2;
    idle(4);
    check("tx", 8'h00, 8'(phy_tx_enable));
    check("rx", 8'h00, 8'(phy_rx_enable));
    check("detect", 8'h00, 8'(energy_detect_enable));
    wr(8'h1D, 8'h00);
    miim_port_power_down = 2'h0;
    $display("mode test done");
    plugged = 2'h0;
    wr(8'hC4, 8'h02);
    wr(8'hC3, 8'h01);
    idle(4);
    check("state", 8'h01, 8'(power_state));
    idle(40);
    st(3'h2, 3'h0);
    check("detect", 8'h03, 8'(energy_detect_enable));
    @(posedge link_pulse[0]);
    @(negedge clk);
    n = 0;
    while (link_pulse[0] === 1'b1 && n < 200)
    begin
      n++;
      @(negedge clk);
    end
    check("width", 8'h1E, 8'(n));
    while (link_pulse[0] === 1'b0 && n < 200)
    begin
      n++;
      @(negedge clk);
    end
    check("period", 8'h64, 8'(n));
    plugged = 2'h1;
    far_active = 2'h1;
    idle(3);
    st(3'h1, 3'h7);
    wr(8'hC3, 8'h00);
    rd(8'hC4, 8'h02);
    $display("energy test done");
    plugged = 2'h0;
    far_active = 2'h0;
    autoneg_enable = 1'b1;
    wr(8'hC3, 8'h03);
    idle(6);
    check("state", 8'h05, 8'(power_state));
    check("rx", 8'h00, 8'(phy_rx_enable));
    check("tx", 8'h03, 8'(phy_tx_enable));
    plugged = 2'h1;
    idle(4);
    check("state", 8'h04, 8'(power_state));
    check("rx", 8'h03, 8'(phy_rx_enable));
    wr(8'hC3, 8'h00);
    $display("saving test done");
    chip_shutdown_n = 1'b0;
    idle(4);
    st(3'h6, 3'h0);
    wr(8'hC3, 8'h02);
    chip_shutdown_n = 1'b1;
    idle(4);
    st(3'h0, 3'h7);
    rd(8'hC3, 8'h00);
    $display("hard down test done");
    clk_en = 1'b0;
    wr(8'hC3, 8'h02);
    idle(2);
    st(3'h0, 3'h7);
    clk_en = 1'b1;
    rd(8'hC3, 8'h00);
    $display("clock enable test done");
    wr(8'hC4, 8'h05);
    wr(8'hC3, 8'h02);
    idle(2);
    st(3'h3, 3'h0);
    @(negedge clk);
    reg_addr = 8'hC3;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    check("refused", 8'h00, 8'(reg_rvalid));
    reset_n = 1'b0;
    idle(2);
    reset_n = 1'b1;
    st(3'h0, 3'h7);
    rd(8'hC3, 8'h00);
    rd(8'hC4, 8'hFF);
    $display("second reset test done");
    test_done();
  end
endmodule : switch_power_mode_control_tb_top
